// ---- src/dma_chan_consts.vh ----
`ifndef DMA_CHAN_CONSTS_VH
`define DMA_CHAN_CONSTS_VH

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define OFS_CTL 4'h0
`define OFS_SRC 4'h4
`define OFS_DST 4'h8
`define OFS_CNT 4'hc

// ----------------------------------------
// channel control fields
// ----------------------------------------
`define CTL_TRIG 0
`define CTL_ABORT 1
`define CTL_IE 2
`define CTL_FLAG 3
`define CTL_EN 4
`define CTL_LEVEL 5
`define CTL_SBYTE 6
`define CTL_DBYTE 7
`define CTL_SINC_LO 8
`define CTL_SINC_HI 9
`define CTL_DINC_LO 10
`define CTL_DINC_HI 11
`define CTL_MODE_LO 12
`define CTL_MODE_HI 14

// ----------------------------------------
// encodings
// ----------------------------------------
`define MODE_SINGLE 2'h0
`define MODE_BLOCK 2'h1
`define INC_DEC 2'h2
`define INC_INC 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CTL 16'h0000
`define RST_PTR 20'h00000
`define RST_CNT 16'h0000

`endif

// ---- src/dma_channel_regs.v ----
// Functional notes
// - completion flag bit 3, readable and writable
// - interrupt enable bit 2 gates channel interrupt
// - nmi abort flag bit 1 set on abort
// - soft trigger bit 0 starts, self-clears
// - source pointer 20 bits, upper reads zero
// - source pointer gives first source address
// - visible source pointer never advances
// - low-half write clears source bits 19-16
// - bits 19-16 reached only by a write with byte lane 2 selected
// - destination pointer 20 bits, upper reads zero
// - visible destination pointer never advances
// - low-half write clears destination bits 19-16
// - 16-bit count sets units per block
// - count decrements once per moved unit
// - count reloads programmed value on the last unit of a block instead of reaching zero
// - programmed count zero moves nothing
// - count 1 to ffff moves that many
// - hidden working pointers step by one/two
// - mode selects single or block, each optionally repeated
`timescale 1ns/1ps
`include "dma_chan_consts.vh"

module dma_channel_regs #(
    parameter AW = 20,
    parameter CW = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // trigger and system events
    input wire trigger_i,
    input wire nmi_i,
    // data mover handshake
    output reg xfer_req_o,
    output reg [AW-1:0] xfer_src_o,
    output reg [AW-1:0] xfer_dst_o,
    output reg xfer_src_byte_o,
    output reg xfer_dst_byte_o,
    input wire xfer_ack_i,
    // status
    output reg busy_o,
    output reg irq_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_MOVE = 1'b1;
    // bit 15 is reserved and bit 0 is a strobe: neither is stored
    localparam [15:0] CTL_KEEP = 16'h7ffe;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function [AW-1:0] step;
        input [AW-1:0] a;
        input [1:0] inc;
        input is_byte;
        reg [AW-1:0] d;
        begin
            // words step by two, bytes by one
            d = is_byte ? {{(AW-1){1'b0}}, 1'b1} : {{(AW-2){1'b0}}, 2'b10};
            if (inc == `INC_INC) begin
                step = a + d;
            end else if (inc == `INC_DEC) begin
                step = a - d;
            end else begin
                step = a;
            end
        end
    endfunction

    // wide write keeps unselected bytes; a low-half-only write clears bits 19-16
    function [AW-1:0] ptr_wr;
        input [AW-1:0] old;
        input [3:0] sel;
        input [31:0] wd;
        reg [AW-1:0] r;
        begin
            r = old;
            if (sel[0]) begin
                r[7:0] = wd[7:0];
            end
            if (sel[1]) begin
                r[15:8] = wd[15:8];
            end
            if (sel[2]) begin
                r[AW-1:16] = wd[AW-1:16];
            end else if (sel[1:0] != 2'b00) begin
                r[AW-1:16] = {(AW-16){1'b0}};
            end
            ptr_wr = r;
        end
    endfunction

    function [15:0] half_wr;
        input [15:0] old;
        input [3:0] sel;
        input [31:0] wd;
        begin
            half_wr = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [31:0] rd_word;
        input [3:0] adr;
        input [15:0] ctl;
        input [AW-1:0] src;
        input [AW-1:0] dst;
        input [CW-1:0] cnt;
        begin
            case (adr)
                // trigger bit always reads zero
                `OFS_CTL: rd_word = {16'h0000, ctl & CTL_KEEP};
                `OFS_SRC: rd_word = {{(32-AW){1'b0}}, src};
                `OFS_DST: rd_word = {{(32-AW){1'b0}}, dst};
                `OFS_CNT: rd_word = {{(32-CW){1'b0}}, cnt};
                default: rd_word = 32'h00000000;
            endcase
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [15:0] ctl_q;
    reg [AW-1:0] src_q;
    reg [AW-1:0] dst_q;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_init_q;
    reg [AW-1:0] wsrc_q;
    reg [AW-1:0] wdst_q;
    reg loaded_q;
    reg soft_q;
    reg trig_q;
    reg pend_q;
    reg st_q;

    // the ack cycle itself is never taken as a new request
    wire acc = cyc_i & stb_i & ~ack_o;
    wire wr = acc & we_i;
    wire wr_ctl = wr & (adr_i == `OFS_CTL);
    wire wr_src = wr & (adr_i == `OFS_SRC);
    wire wr_dst = wr & (adr_i == `OFS_DST);
    wire wr_cnt = wr & (adr_i == `OFS_CNT);

    wire [2:0] mode = ctl_q[`CTL_MODE_HI:`CTL_MODE_LO];
    wire [1:0] sinc = ctl_q[`CTL_SINC_HI:`CTL_SINC_LO];
    wire [1:0] dinc = ctl_q[`CTL_DINC_HI:`CTL_DINC_LO];
    wire sbyte = ctl_q[`CTL_SBYTE];
    wire dbyte = ctl_q[`CTL_DBYTE];
    wire en = ctl_q[`CTL_EN];
    wire repeated = mode[2];
    wire single = (mode[1:0] == `MODE_SINGLE);

    // hardware trigger, edge or level sensitive
    wire hw_trig = ctl_q[`CTL_LEVEL] ? trigger_i : (trigger_i & ~trig_q);
    wire start = en & (cnt_init_q != {CW{1'b0}}) & (soft_q | hw_trig | pend_q);
    wire unit_done = (st_q == ST_MOVE) & xfer_ack_i;
    wire last_unit = unit_done & (cnt_q == {{(CW-1){1'b0}}, 1'b1});
    wire abort = nmi_i & (st_q == ST_MOVE);
    // next working addresses, shared by the step and the advance paths
    wire [AW-1:0] nxt_src = step(xfer_src_o, sinc, sbyte);
    wire [AW-1:0] nxt_dst = step(xfer_dst_o, dinc, dbyte);

    // ----------------------------------------
    // wishbone slave: one wait state, ack one cycle
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= acc;
            if (acc & ~we_i) begin
                dat_o <= rd_word(adr_i, ctl_q, src_q, dst_q, cnt_q);
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= `RST_CTL;
            soft_q <= 1'b0;
        end else begin
            soft_q <= 1'b0;
            if (wr_ctl) begin
                ctl_q <= half_wr(ctl_q, sel_i, dat_i) & CTL_KEEP;
                soft_q <= sel_i[0] & dat_i[`CTL_TRIG];
            end
            // hardware sets win over a same-cycle software clear
            if (last_unit | (unit_done & single)) begin
                ctl_q[`CTL_FLAG] <= 1'b1;
                if (~repeated & last_unit) begin
                    ctl_q[`CTL_EN] <= 1'b0;
                end
            end
            if (abort) begin
                ctl_q[`CTL_ABORT] <= 1'b1;
                ctl_q[`CTL_EN] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pointers and count
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= `RST_PTR;
            dst_q <= `RST_PTR;
            cnt_q <= `RST_CNT;
            cnt_init_q <= `RST_CNT;
        end else begin
            // visible pointers change only by software writes
            if (wr_src) begin
                src_q <= ptr_wr(src_q, sel_i, dat_i);
            end
            if (wr_dst) begin
                dst_q <= ptr_wr(dst_q, sel_i, dat_i);
            end
            if (wr_cnt) begin
                cnt_q <= half_wr(cnt_q, sel_i, dat_i);
                cnt_init_q <= half_wr(cnt_init_q, sel_i, dat_i);
            end else if (last_unit) begin
                cnt_q <= cnt_init_q;
            end else if (unit_done) begin
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------
    // trigger history, unit attributes, interrupt
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            trig_q <= 1'b0;
            xfer_src_byte_o <= 1'b0;
            xfer_dst_byte_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // idles low like the pin, so no false edge follows reset
            trig_q <= trigger_i;
            irq_o <= ctl_q[`CTL_FLAG] & ctl_q[`CTL_IE];
            xfer_src_byte_o <= sbyte;
            xfer_dst_byte_o <= dbyte;
        end
    end

    // ----------------------------------------
    // channel sequencer
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            wsrc_q <= `RST_PTR;
            wdst_q <= `RST_PTR;
            loaded_q <= 1'b0;
            pend_q <= 1'b0;
            xfer_req_o <= 1'b0;
            xfer_src_o <= `RST_PTR;
            xfer_dst_o <= `RST_PTR;
            busy_o <= 1'b0;
        end else begin
            // a trigger seen while moving is kept for the next start, in any mode
            if (st_q == ST_MOVE & (soft_q | hw_trig)) begin
                pend_q <= 1'b1;
            end
            // a trigger kept for a disabled channel must not fire later
            if (~en) begin
                pend_q <= 1'b0;
            end
            if (wr_src | wr_dst | wr_cnt | ~en) begin
                loaded_q <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        pend_q <= 1'b0;
                        st_q <= ST_MOVE;
                        busy_o <= 1'b1;
                        xfer_req_o <= 1'b1;
                        loaded_q <= 1'b1;
                        // a fresh block starts from the visible pointers
                        if (~loaded_q) begin
                            xfer_src_o <= src_q;
                            xfer_dst_o <= dst_q;
                            wsrc_q <= src_q;
                            wdst_q <= dst_q;
                        end else begin
                            xfer_src_o <= wsrc_q;
                            xfer_dst_o <= wdst_q;
                        end
                    end
                end
                ST_MOVE: begin
                    if (abort) begin
                        // count keeps its partial value until software reloads it
                        st_q <= ST_IDLE;
                        busy_o <= 1'b0;
                        xfer_req_o <= 1'b0;
                        loaded_q <= 1'b0;
                    end else if (unit_done) begin
                        wsrc_q <= nxt_src;
                        wdst_q <= nxt_dst;
                        if (last_unit) begin
                            // next block restarts from the visible pointers
                            loaded_q <= 1'b0;
                        end
                        if (single | last_unit) begin
                            st_q <= ST_IDLE;
                            busy_o <= 1'b0;
                            xfer_req_o <= 1'b0;
                        end else begin
                            xfer_src_o <= nxt_src;
                            xfer_dst_o <= nxt_dst;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- dv/dma_channel_regs_checker.sv ----
`timescale 1ns/1ps
module dma_channel_regs_checker #(
    parameter AW = 20,
    parameter CW = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // mover and status
    input wire nmi_i,
    input wire xfer_req_o,
    input wire [AW-1:0] xfer_src_o,
    input wire xfer_ack_i,
    input wire busy_o,
    input wire irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack cycle");
    upper_zero_a: assert property (ack_o |-> dat_o[31:20] == 12'h0)
        else $error("reserved upper bits read nonzero");
    trig_zero_a: assert property (ack_o && adr_i == 4'h0 |-> !dat_o[0])
        else $error("soft trigger bit reads set");
    irq_match_a: assert property (ack_o && !we_i && adr_i == 4'h0 |-> irq_o == (dat_o[3] && dat_o[2]))
        else $error("irq differs from flag and enable");
    req_hold_a: assert property (xfer_req_o && !xfer_ack_i && !nmi_i |=> xfer_req_o && $stable(xfer_src_o))
        else $error("unit request dropped or moved before ack");
    nmi_drop_a: assert property (xfer_req_o && nmi_i |=> !xfer_req_o)
        else $error("request kept through nmi");
    busy_req_a: assert property (xfer_req_o |-> busy_o)
        else $error("request without busy");
endmodule

bind dma_channel_regs dma_channel_regs_checker #(.AW(AW), .CW(CW)) dma_channel_regs_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .nmi_i(nmi_i), .xfer_req_o(xfer_req_o),
    .xfer_src_o(xfer_src_o), .xfer_ack_i(xfer_ack_i), .busy_o(busy_o), .irq_o(irq_o));

// ---- dv/mover_model.sv ----
`timescale 1ns/1ps
// acks each unit one or two cycles after its request; stall holds it off entirely
module mover_model (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // handshake
    input wire req_i,
    input wire stall_i,
    output reg ack_o
);
    reg [1:0] wait_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_q <= 2'h0;
        end else if (req_i && !ack_o && !stall_i && wait_q == 2'h0) begin
            ack_o <= 1'b1;
            wait_q <= 2'($urandom % 3);
        end else begin
            ack_o <= 1'b0;
            if (req_i && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
        end
    end
endmodule

// ---- dv/dma_channel_regs_test.sv ----
`timescale 1ns/1ps
module dma_channel_regs_test;
    reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg trigger_i = 1'b0, nmi_i = 1'b0, stall = 1'b0;
    reg [3:0] adr_i = 4'h0, sel_i = 4'h0;
    reg [31:0] dat_i = 32'h0;
    wire [31:0] dat_o;
    wire [19:0] xfer_src_o, xfer_dst_o;
    wire ack_o, xfer_req_o, xfer_ack_i, busy_o, irq_o;
    wire xfer_src_byte_o, xfer_dst_byte_o;
    reg [1:0] byt = 2'h0;
    int err_total = 0, n_compared = 0, i;
    logic [63:0] rdq[$], q;
    logic [39:0] mvq[$];
    reg [19:0] s, d;
    always #25 clk_i = ~clk_i;
    dma_channel_regs dma_channel_regs_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .trigger_i(trigger_i), .nmi_i(nmi_i), .xfer_req_o(xfer_req_o),
        .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o), .xfer_src_byte_o(xfer_src_byte_o),
        .xfer_dst_byte_o(xfer_dst_byte_o), .xfer_ack_i(xfer_ack_i), .busy_o(busy_o),
        .irq_o(irq_o));
    mover_model mover_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(xfer_req_o),
        .stall_i(stall), .ack_o(xfer_ack_i));
    task end_of_test;
        $display("mismatches %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input [39:0] seen, input [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cycle(input w, input [3:0] a, input [3:0] sl, input [31:0] wd);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, sl, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 20) begin
                err_total++;
                end_of_test;
            end
        end while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'h0;
    endtask
    task rd(input [3:0] a, input [31:0] e, input [31:0] m = 32'hffffffff);
        rdq.push_back({m, e});
        cycle(1'b0, a, 4'hf, 32'h0);
    endtask
    // bounded wait for the channel to go quiet
    task waitidle;
        int n;
        repeat (3) @(posedge clk_i);
        for (n = 0; busy_o !== 1'b0; n++) begin
            @(posedge clk_i);
            if (n > 200) begin
                err_total++;
                end_of_test;
            end
        end
    endtask
    // --------------------------------
    // scoreboard
    // --------------------------------
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we_i) begin
            q = rdq.size() ? rdq.pop_front() : 64'h1;
            chk(dat_o & q[63:32], q[31:0]);
        end
        if (xfer_req_o === 1'b1 && xfer_ack_i === 1'b1) begin
            chk({xfer_src_o, xfer_dst_o}, mvq.size() ? mvq.pop_front() : 40'h1);
            chk({xfer_src_byte_o, xfer_dst_byte_o}, byt);
        end
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        void'($urandom(4));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 5; i++) rd(i == 4 ? 4'h2 : 4'(i << 2), 32'h0);
        for (i = 4; i <= 8; i += 4) begin
            s = $urandom;
            cycle(1'b1, 4'(i), 4'hf, {12'hfff, s});
            rd(4'(i), {12'h0, s});
            cycle(1'b1, 4'(i), 4'h3, 32'h1234);
            rd(4'(i), 32'h1234);
            cycle(1'b1, 4'(i), 4'h4, 32'ha0000);
            rd(4'(i), 32'ha1234);
        end
        cycle(1'b1, 4'h0, 4'hf, 32'hc);
        rd(4'h0, 32'hc);
        // block of three words, both pointers stepping by two
        s = $urandom;
        d = $urandom;
        cycle(1'b1, 4'h4, 4'hf, s);
        cycle(1'b1, 4'h8, 4'hf, d);
        cycle(1'b1, 4'hc, 4'hf, 32'h3);
        for (i = 0; i < 3; i++) mvq.push_back({s + 20'(2 * i), d + 20'(2 * i)});
        cycle(1'b1, 4'h0, 4'hf, 32'h1f15);
        waitidle;
        rd(4'h4, s);
        rd(4'h8, d);
        rd(4'hc, 32'h3);
        rd(4'h0, 32'h1f0c);
        // zero count: any acked unit finds the queue empty
        cycle(1'b1, 4'hc, 4'hf, 32'h0);
        cycle(1'b1, 4'h0, 4'hf, 32'h1f11);
        waitidle;
        // single byte units, software then hardware trigger
        cycle(1'b1, 4'hc, 4'hf, 32'h2);
        byt = 2'h3;
        mvq.push_back({s, d});
        mvq.push_back({s + 20'h1, d});
        cycle(1'b1, 4'h0, 4'hf, 32'h3d1);
        waitidle;
        rd(4'hc, 32'h1);
        rd(4'h0, 32'h8, 32'h8);
        @(posedge clk_i) trigger_i <= 1'b1;
        @(posedge clk_i) trigger_i <= 1'b0;
        waitidle;
        rd(4'hc, 32'h2);
        // repeated block on a level trigger, both pointers stepping down by two
        byt = 2'h0;
        mvq.push_back({s, d});
        mvq.push_back({s - 20'h2, d - 20'h2});
        cycle(1'b1, 4'h0, 4'hf, 32'h5a34);
        @(posedge clk_i) trigger_i <= 1'b1;
        @(posedge clk_i) trigger_i <= 1'b0;
        waitidle;
        rd(4'h0, 32'h5a3c);
        rd(4'hc, 32'h2);
        // nmi while a unit is held off
        stall <= 1'b1;
        cycle(1'b1, 4'hc, 4'hf, 32'h4);
        cycle(1'b1, 4'h0, 4'hf, 32'h1011);
        repeat (3) @(posedge clk_i);
        nmi_i <= 1'b1;
        @(posedge clk_i) nmi_i <= 1'b0;
        stall <= 1'b0;
        waitidle;
        rd(4'h0, 32'h2, 32'h12);
        chk(mvq.size(), 40'h0);
        end_of_test;
    end
endmodule
